// ---- hdl/hmu_hold_unit.sv ----
// Purpose: Hold logic of a transducer indicator with APB registers
// Assumes: A/D samples arrive on clk_sys; buttons and terminals are pins
// Notes:   Hysteresis, setting memories and D/A path are outside
//
// What this block does
// - Peak-to-peak hold tracks max/min, shows difference
// - Hold ends on second press or input off
// - Clear during peak-to-peak hold restarts tracking
// - Peak-to-peak judgment uses the difference
// - Zone keeps final value until a clear or the next hold start
// - Peak-and-bottom tracks extremes, judges all five
// - High on once peak exceeds high limit
// - Pass when both extremes lie inside bands
// - Without pass, bottom drives low and low-low
// - Low peak with deep bottom never passes
// - Zone also latches judgment outputs
// - Outer limits off: pass on both crossings
// - Two-stage average, count 1-999, 20000 first-stage averages
// - Average refreshes once per count measurements
// - Average stops at span end, zone retains
// - Fast sampling raises conversion rate fivefold
// - Fast hold blanks display, then forces zone
// - Fast hold measures from 10 ms after start
// - Analog output strobe stays at base rate
// - External hold input: level or pulse format
// - One setting gates both clear sources
// - Auto zero performs digital zero at hold start
`timescale 1ns/10ps
`default_nettype none
module hmu_hold_unit
    import hmu_pkg::*;
#(
    parameter int unsigned DW       = HMU_DW,
    parameter int unsigned CONV_DIV = HMU_CONV_DIV,
    parameter int unsigned FAST_DIV = HMU_FAST_DIV,
    parameter int unsigned FAST_DLY = HMU_FAST_DLY
) (
    input  wire logic          clk_sys,
    input  wire logic          rst,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          sample_valid,
    input  wire logic [DW-1:0] sample_data,
    input  wire logic          hold_btn,
    input  wire logic          clear_btn,
    input  wire logic          ext_hold,
    input  wire logic          ext_clear,
    output logic               conv_start,
    output logic               conv_fast,
    output logic               dac_update,
    output logic [DW-1:0]      display_value,
    output logic               display_blank,
    output hmu_judge_t         judge,
    output logic               digital_zero,
    output logic               hold_active
);
    localparam int unsigned CW  = $clog2(CONV_DIV + 1);
    localparam int unsigned DLW = $clog2(FAST_DLY + 1);
    localparam int unsigned NW  = DW + 16;
    localparam logic [14:0] AVG_MAX = 15'(HMU_AVG_MAX_SAMPLES);

    hmu_ctrl_t          ctrl_r;
    logic [9:0]         avg_cnt_r;
    logic signed [DW-1:0] lim_hh_r, lim_hi_r, lim_lo_r, lim_ll_r;
    hmu_hstate_t        hs_r;
    hmu_astate_t        as_r;
    logic [3:0]         sy1_r, sy2_r, syp_r;
    logic [DLW-1:0]     dly_r;
    logic [CW-1:0]      conv_cnt_r, dac_cnt_r;
    logic signed [DW-1:0] raw_r, zero_off_r, meas_r, peak_r, bot_r;
    logic signed [DW-1:0] samp_r, avg_r, meas_nxt, p2p, value_nxt;
    logic               empty_r;
    logic signed [DW+9:0]  acc1_r;
    logic signed [DW+14:0] acc2_r;
    logic [9:0]         c1_r;
    logic [14:0]        n2_r;
    logic               div_start_r, div_done, avg_full_r;
    logic [NW-1:0]      div_num_r, div_quo;
    logic [15:0]        div_den_r;
    logic               div_neg_r;
    logic signed [DW-1:0] div_res;
    logic               btn_e, clr_btn_e, ext_rise, ext_fall, ext_lvl;
    logic               clr_ev, start_ev, stop_ev, fastable, fast_hold;
    logic               zone_eff, tracking, running;
    hmu_judge_t         judge_nxt;

    // Pins are asynchronous to clk_sys
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    sy1_r[gi] <= 1'b0;
                    sy2_r[gi] <= 1'b0;
                    syp_r[gi] <= 1'b0;
                end else begin
                    sy1_r[gi] <= gi == 0 ? hold_btn :
                                 gi == 1 ? clear_btn :
                                 gi == 2 ? ext_hold : ext_clear;
                    sy2_r[gi] <= sy1_r[gi];
                    syp_r[gi] <= sy2_r[gi];
                end
            end
        end
    endgenerate

    assign btn_e     = sy2_r[0] & ~syp_r[0];
    assign clr_btn_e = sy2_r[1] & ~syp_r[1];
    assign ext_rise  = sy2_r[2] & ~syp_r[2];
    assign ext_fall  = ~sy2_r[2] & syp_r[2];
    assign ext_lvl   = ~ctrl_r.ext_pulse;

    assign running  = hs_r == HS_WAIT || hs_r == HS_RUN;
    assign fastable = ctrl_r.mode inside {HMU_MODE_PEAK, HMU_MODE_BOTTOM,
                                          HMU_MODE_P2P, HMU_MODE_PB};
    assign fast_hold = running && ctrl_r.fast && fastable;
    // Sample hold has no clear; one bit gates both sources
    assign clr_ev = ctrl_r.clear_en && (clr_btn_e || (sy2_r[3] & ~syp_r[3]))
                    && ctrl_r.mode != HMU_MODE_SAMPLE;
    assign start_ev = !running && ctrl_r.mode != HMU_MODE_OFF
                      && (btn_e || ext_rise);
    assign stop_ev = running && (btn_e || (ext_lvl ? ext_fall : ext_rise)
                     || avg_full_r);
    assign zone_eff = ctrl_r.mode != HMU_MODE_SAMPLE
                      && (ctrl_r.zone || (ctrl_r.fast && fastable));
    assign tracking = hs_r == HS_RUN && sample_valid;

    // Hold sequencing
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hs_r         <= HS_IDLE;
            dly_r        <= '0;
            digital_zero <= 1'b0;
            zero_off_r   <= '0;
        end else begin
            digital_zero <= 1'b0;
            if (start_ev) begin
                hs_r  <= ctrl_r.fast && fastable ? HS_WAIT : HS_RUN;
                dly_r <= DLW'(FAST_DLY);
                if (ctrl_r.auto_zero) begin
                    zero_off_r   <= raw_r;
                    digital_zero <= 1'b1;
                end
            end else if (stop_ev) begin
                hs_r <= zone_eff ? HS_ZONE : HS_IDLE;
            end else if (hs_r == HS_WAIT) begin
                dly_r <= dly_r - 1'b1;
                if (dly_r <= 1)
                    hs_r <= HS_RUN;
            end else if (hs_r == HS_ZONE && clr_ev) begin
                hs_r <= HS_IDLE;
            end
        end
    end

    // Conversion and analog output strobes
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            conv_cnt_r <= '0;
            conv_start <= 1'b0;
            conv_fast  <= 1'b0;
        end else begin
            conv_fast <= fast_hold;
            if (conv_cnt_r == '0) begin
                conv_cnt_r <= fast_hold ? CW'(FAST_DIV - 1)
                                        : CW'(CONV_DIV - 1);
                conv_start <= 1'b1;
            end else begin
                conv_cnt_r <= conv_cnt_r - 1'b1;
                conv_start <= 1'b0;
            end
        end
    end

    // Own divider so fast sampling never changes this rate
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dac_cnt_r  <= '0;
            dac_update <= 1'b0;
        end else begin
            dac_update <= dac_cnt_r == '0;
            dac_cnt_r  <= dac_cnt_r == '0 ? CW'(CONV_DIV - 1)
                                          : dac_cnt_r - 1'b1;
        end
    end

    assign meas_nxt = sample_data - zero_off_r;

    // Extreme tracking
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            raw_r   <= '0;
            meas_r  <= '0;
            peak_r  <= '0;
            bot_r   <= '0;
            samp_r  <= '0;
            empty_r <= 1'b1;
        end else begin
            if (sample_valid) begin
                raw_r  <= sample_data;
                meas_r <= meas_nxt;
            end
            if (start_ev) begin
                empty_r <= 1'b1;
                samp_r  <= meas_r;
            end else if (running && clr_ev) begin
                empty_r <= 1'b1;
            end else if (tracking) begin
                empty_r <= 1'b0;
                if (empty_r || meas_nxt > peak_r)
                    peak_r <= meas_nxt;
                if (empty_r || meas_nxt < bot_r)
                    bot_r <= meas_nxt;
            end
        end
    end

    assign p2p = peak_r - bot_r;

    // Two-stage averager sharing one divider
    assign div_res = div_neg_r ? -DW'(div_quo) : DW'(div_quo);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            as_r        <= AV_IDLE;
            acc1_r      <= '0;
            acc2_r      <= '0;
            c1_r        <= '0;
            n2_r        <= '0;
            avg_r       <= '0;
            avg_full_r  <= 1'b0;
            div_start_r <= 1'b0;
            div_num_r   <= '0;
            div_den_r   <= '0;
            div_neg_r   <= 1'b0;
        end else begin
            div_start_r <= 1'b0;
            avg_full_r  <= 1'b0;
            if (start_ev || (running && clr_ev)) begin
                as_r   <= AV_IDLE;
                acc1_r <= '0;
                acc2_r <= '0;
                c1_r   <= '0;
                n2_r   <= '0;
            end else if (ctrl_r.mode == HMU_MODE_AVG && hs_r == HS_RUN) begin
                if (sample_valid) begin
                    if (c1_r + 10'h001 >= avg_cnt_r && as_r == AV_IDLE) begin
                        div_num_r   <= NW'(acc1_r + meas_nxt < 0
                                       ? -(acc1_r + meas_nxt)
                                       : acc1_r + meas_nxt);
                        div_neg_r   <= acc1_r + meas_nxt < 0;
                        div_den_r   <= {6'h00, avg_cnt_r};
                        div_start_r <= 1'b1;
                        as_r        <= AV_DIV1;
                        acc1_r      <= '0;
                        c1_r        <= '0;
                    end else begin
                        acc1_r <= acc1_r + meas_nxt;
                        c1_r   <= c1_r + 10'h001;
                    end
                end
                if (div_done && as_r == AV_DIV1) begin
                    div_num_r   <= NW'(acc2_r + div_res < 0
                                   ? -(acc2_r + div_res)
                                   : acc2_r + div_res);
                    div_neg_r   <= acc2_r + div_res < 0;
                    div_den_r   <= {1'b0, n2_r + 15'h0001};
                    acc2_r      <= acc2_r + div_res;
                    n2_r        <= n2_r + 15'h0001;
                    div_start_r <= 1'b1;
                    as_r        <= AV_DIV2;
                end else if (div_done && as_r == AV_DIV2) begin
                    avg_r <= div_res;
                    as_r  <= AV_IDLE;
                    if (n2_r >= AVG_MAX)
                        avg_full_r <= 1'b1;
                end
            end
        end
    end

    hmu_div #(
        .NW  (NW),
        .DDW (16)
    ) u_div (
        .clk_sys (clk_sys),
        .rst     (rst),
        .start   (div_start_r),
        .num     (div_num_r),
        .den     (div_den_r),
        .done    (div_done),
        .quo     (div_quo)
    );

    // Value and judgment selection
    always_comb begin
        value_nxt = meas_r;
        if (running && !(empty_r && ctrl_r.mode != HMU_MODE_SAMPLE
                         && ctrl_r.mode != HMU_MODE_AVG)) begin
            case (ctrl_r.mode)
                HMU_MODE_SAMPLE: value_nxt = samp_r;
                HMU_MODE_PEAK:   value_nxt = peak_r;
                HMU_MODE_BOTTOM: value_nxt = bot_r;
                HMU_MODE_AVG:    value_nxt = avg_r;
                HMU_MODE_P2P:    value_nxt = p2p;
                HMU_MODE_PB:     value_nxt = peak_r;
                default:         value_nxt = meas_r;
            endcase
        end
        judge_nxt = '0;
        if (ctrl_r.mode == HMU_MODE_PB && running && !empty_r) begin
            // Pass checked first since it masks low outputs
            judge_nxt.hh = ctrl_r.hh_ll_en && peak_r > lim_hh_r;
            judge_nxt.hi = peak_r > lim_hi_r;
            if (ctrl_r.hh_ll_en)
                judge_nxt.ok = peak_r > lim_hi_r && peak_r < lim_hh_r
                    && bot_r < lim_lo_r && bot_r > lim_ll_r;
            else
                judge_nxt.ok = peak_r > lim_hi_r
                    && bot_r < lim_lo_r;
            judge_nxt.lo = !judge_nxt.ok && bot_r < lim_lo_r;
            judge_nxt.ll = !judge_nxt.ok && ctrl_r.hh_ll_en
                           && bot_r < lim_ll_r;
        end else begin
            judge_nxt.hh = ctrl_r.hh_ll_en && value_nxt > lim_hh_r;
            judge_nxt.hi = value_nxt > lim_hi_r;
            judge_nxt.lo = value_nxt < lim_lo_r;
            judge_nxt.ll = ctrl_r.hh_ll_en && value_nxt < lim_ll_r;
            judge_nxt.ok = !(judge_nxt.hh | judge_nxt.hi | judge_nxt.lo
                             | judge_nxt.ll);
        end
    end

    // Zone freezes both value and judgment
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            display_value <= '0;
            judge         <= '0;
            display_blank <= 1'b0;
            hold_active   <= 1'b0;
        end else begin
            hold_active   <= running;
            display_blank <= fast_hold;
            if (hs_r != HS_ZONE) begin
                display_value <= value_nxt;
                judge         <= judge_nxt;
            end
        end
    end

    // APB slave, answers in the access cycle
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl_r    <= hmu_ctrl_t'(HMU_CTRL_RST);
            avg_cnt_r <= HMU_AVGCNT_RST;
            lim_hh_r  <= '0;
            lim_hi_r  <= '0;
            lim_lo_r  <= '0;
            lim_ll_r  <= '0;
        end else if (psel && penable && pwrite) begin
            case (paddr)
                HMU_ADDR_CTRL:   ctrl_r <= hmu_ctrl_t'(pwdata[8:0]);
                HMU_ADDR_AVGCNT: avg_cnt_r <=
                    pwdata[9:0] < HMU_AVG_CNT_MIN ? HMU_AVG_CNT_MIN :
                    pwdata[9:0] > HMU_AVG_CNT_MAX || pwdata[31:10] != '0
                    ? HMU_AVG_CNT_MAX : pwdata[9:0];
                HMU_ADDR_HH:     lim_hh_r <= pwdata[DW-1:0];
                HMU_ADDR_HI:     lim_hi_r <= pwdata[DW-1:0];
                HMU_ADDR_LO:     lim_lo_r <= pwdata[DW-1:0];
                HMU_ADDR_LL:     lim_ll_r <= pwdata[DW-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= '0;
            if (psel && !penable) begin
                case (paddr)
                    HMU_ADDR_CTRL:   prdata <= {23'h0, ctrl_r};
                    HMU_ADDR_AVGCNT: prdata <= {22'h0, avg_cnt_r};
                    HMU_ADDR_HH:     prdata <= 32'(lim_hh_r);
                    HMU_ADDR_HI:     prdata <= 32'(lim_hi_r);
                    HMU_ADDR_LO:     prdata <= 32'(lim_lo_r);
                    HMU_ADDR_LL:     prdata <= 32'(lim_ll_r);
                    HMU_ADDR_STATUS: prdata <= {25'h0, hs_r, judge};
                    HMU_ADDR_VALUE:  prdata <= 32'(display_value);
                    default:         pslverr <= 1'b1;
                endcase
            end
        end
    end
endmodule // hmu_hold_unit
`default_nettype wire

// ---- hdl/hmu_pkg.sv ----
// Purpose: Shared constants and types for the measurement hold unit
// Assumes: 50 MHz system clock, APB register access
// Notes:   Offsets are byte addresses of 32-bit registers
package hmu_pkg;

    localparam int unsigned HMU_DW        = 24;
    localparam int unsigned HMU_CLK_HZ    = 50_000_000;
    localparam int unsigned HMU_MEAS_RATE = 4000;
    localparam int unsigned HMU_FAST_RATE = 20000;
    localparam int unsigned HMU_CONV_DIV  = HMU_CLK_HZ / HMU_MEAS_RATE;
    localparam int unsigned HMU_FAST_DIV  = HMU_CLK_HZ / HMU_FAST_RATE;
    localparam int unsigned HMU_FAST_DLY_MS = 10;
    localparam int unsigned HMU_FAST_DLY  =
        (HMU_CLK_HZ / 1000) * HMU_FAST_DLY_MS;
    localparam int unsigned HMU_AVG_MAX_SAMPLES = 20000;
    localparam logic [9:0]  HMU_AVG_CNT_MIN = 10'h001;
    localparam logic [9:0]  HMU_AVG_CNT_MAX = 10'h3e7;

    localparam logic [7:0] HMU_ADDR_CTRL   = 8'h00;
    localparam logic [7:0] HMU_ADDR_AVGCNT = 8'h04;
    localparam logic [7:0] HMU_ADDR_HH     = 8'h08;
    localparam logic [7:0] HMU_ADDR_HI     = 8'h0c;
    localparam logic [7:0] HMU_ADDR_LO     = 8'h10;
    localparam logic [7:0] HMU_ADDR_LL     = 8'h14;
    localparam logic [7:0] HMU_ADDR_STATUS = 8'h18;
    localparam logic [7:0] HMU_ADDR_VALUE  = 8'h1c;

    localparam logic [8:0] HMU_CTRL_RST   = 9'h040;
    localparam logic [9:0] HMU_AVGCNT_RST = 10'h001;

    typedef enum logic [2:0] {
        HMU_MODE_OFF, HMU_MODE_SAMPLE, HMU_MODE_PEAK, HMU_MODE_BOTTOM,
        HMU_MODE_AVG, HMU_MODE_P2P, HMU_MODE_PB
    } hmu_mode_t;

    typedef struct packed {
        logic      hh_ll_en;
        logic      auto_zero;
        logic      clear_en;
        logic      ext_pulse;
        logic      fast;
        logic      zone;
        hmu_mode_t mode;
    } hmu_ctrl_t;

    typedef struct packed {
        logic hh;
        logic hi;
        logic ok;
        logic lo;
        logic ll;
    } hmu_judge_t;

    typedef enum logic [1:0] {HS_IDLE, HS_WAIT, HS_RUN, HS_ZONE} hmu_hstate_t;
    typedef enum logic [1:0] {AV_IDLE, AV_DIV1, AV_DIV2} hmu_astate_t;

endpackage

// ---- hdl/hmu_div.sv ----
// Purpose: Sequential unsigned restoring divider for the averager
// Assumes: start only while idle; den nonzero
// Notes:   One quotient bit per clock, done pulses with quo valid
`timescale 1ns/10ps
`default_nettype none
module hmu_div #(
    parameter int unsigned NW  = 40,
    parameter int unsigned DDW = 16
) (
    input  wire logic           clk_sys,
    input  wire logic           rst,
    input  wire logic           start,
    input  wire logic [NW-1:0]  num,
    input  wire logic [DDW-1:0] den,
    output logic                done,
    output logic [NW-1:0]       quo
);
    logic [DDW:0]           rem_r;
    logic [DDW:0]           rem_sh;
    logic [DDW-1:0]         den_r;
    logic [$clog2(NW+1)-1:0] cnt_r;
    logic                   busy_r;

    assign rem_sh = {rem_r[DDW-1:0], quo[NW-1]};

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rem_r  <= '0;
            den_r  <= '0;
            quo    <= '0;
            cnt_r  <= '0;
            busy_r <= 1'b0;
            done   <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                rem_r  <= '0;
                den_r  <= den;
                quo    <= num;
                cnt_r  <= ($clog2(NW+1))'(NW);
                busy_r <= 1'b1;
            end else if (busy_r) begin
                if (rem_sh >= {1'b0, den_r}) begin
                    rem_r <= rem_sh - {1'b0, den_r};
                    quo   <= {quo[NW-2:0], 1'b1};
                end else begin
                    rem_r <= rem_sh;
                    quo   <= {quo[NW-2:0], 1'b0};
                end
                cnt_r <= cnt_r - 1'b1;
                if (cnt_r == 1) begin
                    busy_r <= 1'b0;
                    done   <= 1'b1;
                end
            end
        end
    end
endmodule // hmu_div
`default_nettype wire

// ---- tb/hmu_hold_unit_asserts.sv ----
// Purpose: Port-level checks of the hold unit
// Assumes: One clock domain, rst async high
// Notes:   Bound into the hold unit
`timescale 1ns/10ps
`default_nettype none
module hmu_hold_unit_asserts
    import hmu_pkg::*;
#(
    parameter int unsigned CONV_DIV = HMU_CONV_DIV
) (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        dac_update,
    input wire logic        display_blank,
    input wire hmu_judge_t  judge,
    input wire logic        digital_zero,
    input wire logic        hold_active
);
    int unsigned dcnt_r;
    logic        dseen_r;
    // Period counted after first strobe
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dcnt_r  <= 0;
            dseen_r <= 1'b0;
        end else begin
            dcnt_r  <= dac_update ? 0 : dcnt_r + 1;
            dseen_r <= dseen_r | dac_update;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_pready_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_slverr_map: assert property (pready |-> pslverr == (paddr > 8'h1c))
        else $error("pslverr wrong for address");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero outside access");
    a_dac_period: assert property (
        dac_update && dseen_r |-> dcnt_r == CONV_DIV - 1)
        else $error("analog strobe period wrong");
    a_zero_start: assert property (
        digital_zero |-> !hold_active ##1 hold_active)
        else $error("digital zero outside hold start");
    a_zero_pulse: assert property (digital_zero |=> !digital_zero)
        else $error("digital zero longer than a cycle");
    a_ok_excl: assert property (judge.ok |-> !(judge.lo || judge.ll))
        else $error("pass together with low judgment");
    a_blank_hold: assert property (
        display_blank |-> hold_active || $past(hold_active))
        else $error("display blank without hold");
endmodule // hmu_hold_unit_asserts
bind hmu_hold_unit hmu_hold_unit_asserts #(.CONV_DIV(CONV_DIV)) u_chk (.*);
`default_nettype wire

// ---- tb/hmu_pins_model.sv ----
// Purpose: Operator buttons and control input terminals
// Assumes: Clean levels, no contact bounce
// Notes:   Levels kept 6 cycles for the synchroniser
`timescale 1ns/10ps
`default_nettype none
module hmu_pins_model (
    input  wire logic clk_sys,
    output logic      hold_btn,
    output logic      clear_btn,
    output logic      ext_hold,
    output logic      ext_clear
);
    logic [3:0] pin_r = 4'h0;
    assign {ext_clear, ext_hold, clear_btn, hold_btn} = pin_r;
    task automatic set(input int n, input logic v);
        @(posedge clk_sys);
        pin_r[n] <= v;
        repeat (6) @(posedge clk_sys);
    endtask
    task automatic pulse(input int n);
        set(n, 1'b1);
        set(n, 1'b0);
    endtask
endmodule // hmu_pins_model
`default_nettype wire

// ---- tb/tb.sv ----
// Purpose: Self-checking bench for the hold unit
// Assumes: Shortened dividers
// Notes:   Limits 100, 50, -50, -100
`timescale 1ns/10ps
`default_nettype none
module tb;
    import hmu_pkg::*;
    logic        clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic        sample_valid = 0, pready, pslverr, rerr, dz = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, rdv;
    logic [23:0] sample_data = 0, dv;
    logic        hold_btn, clear_btn, ext_hold, ext_clear;
    logic        conv_fast, blank, digital_zero, ha;
    hmu_judge_t  judge;
    int          num_errors = 0, compares = 0;
    hmu_pins_model pins (.clk_sys(clk_sys), .hold_btn(hold_btn),
        .clear_btn(clear_btn), .ext_hold(ext_hold), .ext_clear(ext_clear));
    hmu_hold_unit #(.CONV_DIV(50), .FAST_DIV(10), .FAST_DLY(50)) dut (
        .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid),
        .sample_data(sample_data), .hold_btn(hold_btn),
        .clear_btn(clear_btn), .ext_hold(ext_hold), .ext_clear(ext_clear),
        .conv_start(), .conv_fast(conv_fast), .dac_update(),
        .display_value(dv), .display_blank(blank), .judge(judge),
        .digital_zero(digital_zero), .hold_active(ha));
    initial forever #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (digital_zero === 1'b1) dz <= 1'b1;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rdv = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic put(input logic [23:0] v);
        @(posedge clk_sys);
        sample_data <= v;
        sample_valid <= 1'b1;
        @(posedge clk_sys);
        sample_valid <= 1'b0;
        repeat (100) @(posedge clk_sys);
    endtask
    task automatic fin(input string s);
        $display("test %s done", s);
    endtask
    task automatic end_sim;
        $display("compares=%0d num_errors=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        end_sim();
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        apb(0, HMU_ADDR_CTRL, 0);
        chk(rdv, 32'h040);
        apb(0, 8'h20, 0);
        chk({rdv[30:0], rerr}, 32'h1);
        apb(1, HMU_ADDR_HH, 32'h64);
        apb(1, HMU_ADDR_HI, 32'h32);
        apb(1, HMU_ADDR_LO, 32'hffffffce);
        apb(1, HMU_ADDR_LL, 32'hffffff9c);
        fin("regs");
        apb(1, HMU_ADDR_CTRL, 32'h045);
        pins.pulse(0);
        put(24'h28);
        put(24'hffffe2);
        chk(dv, 32'h46);
        chk(judge, 32'h08);
        pins.pulse(3);
        put(24'h2);
        chk(dv, 32'h0);
        chk(dz, 32'h0);
        pins.pulse(0);
        chk(ha, 32'h0);
        fin("p2p");
        apb(1, HMU_ADDR_CTRL, 32'h14e);
        pins.pulse(0);
        put(24'h46);
        put(24'hffffba);
        chk(judge & 5'h07, 32'h4);
        chk(dv, 32'h46);
        pins.pulse(1);
        put(24'h14);
        put(24'hffff88);
        chk(judge, 32'h03);
        pins.pulse(0);
        chk(dv, 32'h14);
        apb(0, HMU_ADDR_STATUS, 0);
        chk(rdv, 32'h63);
        pins.pulse(1);
        apb(0, HMU_ADDR_STATUS, 0);
        chk(rdv & 32'h60, 32'h0);
        apb(1, HMU_ADDR_CTRL, 32'h046);
        pins.pulse(0);
        put(24'h46);
        put(24'hffffba);
        chk(judge & 5'h07, 32'h4);
        pins.pulse(0);
        fin("pb");
        apb(1, HMU_ADDR_CTRL, 32'h065);
        pins.pulse(2);
        chk(ha, 32'h1);
        pins.pulse(2);
        chk(ha, 32'h0);
        apb(1, HMU_ADDR_CTRL, 32'h045);
        pins.set(2, 1'b1);
        chk(ha, 32'h1);
        pins.set(2, 1'b0);
        chk(ha, 32'h0);
        fin("ext");
        apb(1, HMU_ADDR_CTRL, 32'h005);
        pins.pulse(0);
        put(24'h28);
        put(24'hffffe2);
        pins.pulse(1);
        pins.pulse(3);
        put(24'h0);
        chk(dv, 32'h46);
        pins.pulse(0);
        apb(1, HMU_ADDR_CTRL, 32'h0c5);
        pins.pulse(0);
        chk(dz, 32'h1);
        pins.pulse(0);
        fin("clear_zero");
        apb(1, HMU_ADDR_CTRL, 32'h052);
        pins.pulse(0);
        chk(blank, 32'h1);
        put(24'h5a);
        chk(conv_fast, 32'h1);
        put(24'h28);
        pins.pulse(0);
        chk(blank, 32'h0);
        chk(dv, 32'h28);
        pins.pulse(1);
        fin("fast");
        apb(1, HMU_ADDR_AVGCNT, 32'h3e8);
        apb(0, HMU_ADDR_AVGCNT, 0);
        chk(rdv, 32'h3e7);
        apb(1, HMU_ADDR_AVGCNT, 32'h2);
        apb(1, HMU_ADDR_CTRL, 32'h044);
        pins.pulse(0);
        put(24'h0a);
        put(24'h14);
        chk(dv, 32'h0f);
        put(24'h1e);
        put(24'h28);
        chk(dv, 32'h19);
        pins.pulse(0);
        fin("avg");
        end_sim();
    end
endmodule // tb
`default_nettype wire
